//--- logic/iso_split_map.vh
// constants for the isochronous split sequencer
`ifndef ISO_SPLIT_MAP_VH
`define ISO_SPLIT_MAP_VH
`define UFRAMES_PER_FRAME 4'd8
`define ITHRESH_RESET 8'h08
`define ST_DO_START 1'b0
`define ST_DO_COMPLETE 1'b1
`define TEST_OFF 3'h0
`define TEST_J 3'h1
`define TEST_K 3'h2
`define TEST_SE0_NAK 3'h3
`define TEST_PACKET 3'h4
`define TEST_FORCE_EN 3'h5
`define RSP_NONE 2'h0
`define RSP_NYET 2'h1
`define RSP_MDATA 2'h2
`define RSP_DATA 2'h3
`define SITD_W 24
`define F_ACTIVE 23
`define F_STATE 22
`define F_BPT 21
`define F_IOC 20
`define F_SMASK_HI 19
`define F_SMASK_LO 12
`define F_CMASK_HI 11
`define F_CMASK_LO 4
`define F_XFER_HI 3
`define F_XFER_LO 0
`endif

//--- logic/sync_fifo.v
// small synchronous fifo with valid/ready on both sides
module sync_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rp_q];
    always @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

//--- logic/irq_threshold.v
// holds completion interrupts until the threshold interval closes
module irq_threshold (
    // clock and reset
    input wire clk,
    input wire reset,
    // timing and control
    input wire uframe_tick,
    input wire [7:0] threshold,
    input wire irq_enable,
    // events
    input wire completion,
    output reg irq_q
);
    reg [7:0] cnt_q;
    reg pend_q;
    wire close = uframe_tick && (cnt_q + 8'h01 >= threshold);
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 8'h00;
            pend_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (close) begin
                cnt_q <= 8'h00;
            end else if (uframe_tick) begin
                cnt_q <= cnt_q + 8'h01;
            end
            // a completion in the closing cycle waits for the next interval
            if (close) begin
                irq_q <= pend_q && irq_enable;
                pend_q <= completion;
            end else if (completion) begin
                pend_q <= 1'b1;
            end
        end
    end
endmodule

//--- logic/iso_split_seq.v
// isochronous split sequencer with port test control and deferred interrupts
`include "iso_split_map.vh"
module iso_split_seq #(
    parameter FIFO_DEPTH = 4
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // schedule entry fetch: current and previous siTD
    input wire entry_valid,
    output reg entry_ready_q,
    input wire [`SITD_W-1:0] cur_entry,
    input wire [`SITD_W-1:0] prev_entry,
    // microframe timing
    input wire [2:0] uframe,
    input wire uframe_tick,
    // transaction translator handshake
    output reg start_split_q,
    output reg complete_split_q,
    output reg use_prev_q,
    input wire rsp_valid,
    input wire [1:0] rsp_code,
    // write back stream
    output reg wb_valid_q,
    input wire wb_ready,
    output reg [`SITD_W-1:0] wb_data_q,
    output reg wb_is_prev_q,
    // control
    input wire run_control,
    input wire controller_reset,
    input wire device_mode,
    input wire [2:0] port_test_sel,
    input wire [7:0] irq_threshold_in,
    input wire threshold_write,
    input wire irq_enable,
    // status
    output reg controller_halted_flag_q,
    output reg [2:0] test_active_q,
    output reg sof_enable_q,
    output reg retired_q,
    output reg [7:0] irq_threshold_q,
    output reg irq_q
);
    localparam S_IDLE = 3'd0;
    localparam S_EVAL = 3'd1;
    localparam S_PREV = 3'd2;
    localparam S_WAIT = 3'd3;
    localparam S_WB = 3'd4;
    reg [2:0] st_q;
    reg [`SITD_W-1:0] cur_q;
    reg [`SITD_W-1:0] prev_q;
    reg on_prev_q;
    reg completion_q;
    wire irq_w;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`SITD_W:0] fifo_out_data;
    // output word refills only once the drain side has taken it
    wire wb_load = fifo_out_valid && (!wb_valid_q || wb_ready);
    reg push_q;
    reg [`SITD_W:0] push_data_q;
    wire [7:0] smask = cur_q[`F_SMASK_HI:`F_SMASK_LO];
    wire [7:0] cmask = cur_q[`F_CMASK_HI:`F_CMASK_LO];
    wire [7:0] pcmask = prev_q[`F_CMASK_HI:`F_CMASK_LO];
    wire [7:0] ubit = 8'h01 << uframe;
    // back pointer used only from current entry, never from previous
    wire need_prev = cur_q[`F_STATE] == `ST_DO_COMPLETE &&
        ((uframe == 3'd0 && !cur_q[`F_BPT]) || (uframe == 3'd1 && !smask[0]));
    // write back passes through the fifo so memory stalls back up the sequencer
    sync_fifo #(.WIDTH(`SITD_W + 1), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) wb_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(push_q),
        .in_ready(fifo_in_ready),
        .in_data(push_data_q),
        .out_valid(fifo_out_valid),
        .out_ready(wb_load),
        .out_data(fifo_out_data)
    );
    irq_threshold irq_unit (
        .clk(clk),
        .reset(reset),
        .uframe_tick(uframe_tick),
        .threshold(irq_threshold_q),
        .irq_enable(irq_enable),
        .completion(completion_q),
        .irq_q(irq_w)
    );
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_valid_q <= 1'b0;
            wb_data_q <= {`SITD_W{1'b0}};
            wb_is_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wb_load) begin
                wb_valid_q <= 1'b1;
                wb_data_q <= fifo_out_data[`SITD_W-1:0];
                wb_is_prev_q <= fifo_out_data[`SITD_W];
            end else if (wb_ready) begin
                wb_valid_q <= 1'b0;
            end
            irq_q <= irq_w;
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_threshold_q <= `ITHRESH_RESET;
            controller_halted_flag_q <= 1'b1;
            test_active_q <= `TEST_OFF;
            sof_enable_q <= 1'b0;
        end else begin
            if (threshold_write) begin
                irq_threshold_q <= (irq_threshold_in == 8'h00) ? 8'h01 : irq_threshold_in;
            end
            controller_halted_flag_q <= !run_control && st_q == S_IDLE;
            if (controller_reset) begin
                test_active_q <= `TEST_OFF;
            end else if (port_test_sel != `TEST_OFF && port_test_sel <= `TEST_FORCE_EN
                    && (!device_mode || run_control)) begin
                test_active_q <= port_test_sel;
            end
            sof_enable_q <= (test_active_q == `TEST_FORCE_EN) ? run_control
                : (run_control && test_active_q == `TEST_OFF);
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= S_IDLE;
            cur_q <= {`SITD_W{1'b0}};
            prev_q <= {`SITD_W{1'b0}};
            on_prev_q <= 1'b0;
            entry_ready_q <= 1'b0;
            start_split_q <= 1'b0;
            complete_split_q <= 1'b0;
            use_prev_q <= 1'b0;
            retired_q <= 1'b0;
            completion_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= {(`SITD_W+1){1'b0}};
        end else begin
            entry_ready_q <= 1'b0;
            start_split_q <= 1'b0;
            complete_split_q <= 1'b0;
            completion_q <= 1'b0;
            push_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (run_control && test_active_q == `TEST_OFF && entry_valid && fifo_in_ready) begin
                        entry_ready_q <= 1'b1;
                        cur_q <= cur_entry;
                        prev_q <= prev_entry;
                        on_prev_q <= 1'b0;
                        st_q <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    use_prev_q <= 1'b0;
                    if (!cur_q[`F_ACTIVE]) begin
                        st_q <= S_IDLE;
                    end else if (need_prev) begin
                        if (prev_q[`F_ACTIVE] && prev_q[`F_STATE] == `ST_DO_COMPLETE && (pcmask & ubit) != 8'h00) begin
                            complete_split_q <= 1'b1;
                            use_prev_q <= 1'b1;
                            on_prev_q <= 1'b1;
                            st_q <= S_WAIT;
                        end else begin
                            st_q <= S_PREV;
                        end
                    end else if (cur_q[`F_STATE] == `ST_DO_START) begin
                        if ((smask & ubit) != 8'h00) begin
                            start_split_q <= 1'b1;
                            cur_q[`F_STATE] <= `ST_DO_COMPLETE;
                            st_q <= S_WB;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end else if ((cmask & ubit) != 8'h00) begin
                        complete_split_q <= 1'b1;
                        st_q <= S_WAIT;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
                S_PREV: begin
                    // previous already retired: current goes back to start
                    if (!prev_q[`F_ACTIVE]) begin
                        retired_q <= 1'b1;
                        cur_q[`F_STATE] <= `ST_DO_START;
                        st_q <= S_WB;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    if (rsp_valid) begin
                        use_prev_q <= 1'b0;
                        if (on_prev_q) begin
                            if (rsp_code == `RSP_MDATA) begin
                                prev_q[`F_XFER_HI:`F_XFER_LO] <= prev_q[`F_XFER_HI:`F_XFER_LO] + 4'h1;
                                push_data_q <= {1'b1, prev_q[`SITD_W-1:`F_XFER_HI+1],
                                    prev_q[`F_XFER_HI:`F_XFER_LO] + 4'h1};
                                push_q <= 1'b1;
                                st_q <= S_IDLE;
                            end else if (rsp_code == `RSP_DATA) begin
                                push_data_q <= {1'b1, 1'b0, prev_q[`SITD_W-2:`F_XFER_HI+1],
                                    prev_q[`F_XFER_HI:`F_XFER_LO] + 4'h1};
                                push_q <= 1'b1;
                                completion_q <= prev_q[`F_IOC];
                                retired_q <= 1'b1;
                                cur_q[`F_STATE] <= `ST_DO_START;
                                st_q <= S_WB;
                            end else begin
                                st_q <= S_IDLE;
                            end
                        end else if (rsp_code == `RSP_DATA) begin
                            cur_q[`F_XFER_HI:`F_XFER_LO] <= cur_q[`F_XFER_HI:`F_XFER_LO] + 4'h1;
                            cur_q[`F_STATE] <= `ST_DO_START;
                            cur_q[`F_ACTIVE] <= 1'b0;
                            completion_q <= cur_q[`F_IOC];
                            st_q <= S_WB;
                        end else if (rsp_code == `RSP_MDATA) begin
                            cur_q[`F_XFER_HI:`F_XFER_LO] <= cur_q[`F_XFER_HI:`F_XFER_LO] + 4'h1;
                            st_q <= S_WB;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end else if (uframe_tick) begin
                        // a silent translator must not hold the schedule past its microframe
                        use_prev_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                S_WB: begin
                    if (fifo_in_ready && !push_q) begin
                        push_q <= 1'b1;
                        push_data_q <= {1'b0, cur_q};
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

//--- test/iso_split_seq_checker.sv
// port assertions for the split sequencer
module iso_split_seq_checker (
    // clock and reset
    input logic clk,
    input logic reset,
    // controls
    input logic entry_valid,
    input logic run_control,
    input logic controller_reset,
    input logic irq_enable,
    // status
    input logic entry_ready_q,
    input logic start_split_q,
    input logic controller_halted_flag_q,
    input logic [2:0] test_active_q,
    input logic sof_enable_q,
    input logic [7:0] irq_threshold_q,
    input logic irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    split_pulse_a: assert property (start_split_q |=> !start_split_q)
        else $error("start pulse too long");
    take_cause_a: assert property (entry_ready_q |-> $past(entry_valid) && $past(run_control))
        else $error("entry taken without request");
    take_split_a: assert property (start_split_q |-> $past(entry_ready_q))
        else $error("start split without a visit");
    halt_run_a: assert property (run_control [*2] |-> !controller_halted_flag_q)
        else $error("halted while running");
    thresh_reset_a: assert property ($fell(reset) |-> irq_threshold_q == 8'h08)
        else $error("threshold reset value");
    irq_mask_a: assert property (irq_q |-> $past(irq_enable, 2))
        else $error("masked interrupt raised");
    irq_pulse_a: assert property (irq_q |=> !irq_q)
        else $error("interrupt longer than a pulse");
    sof_force_a: assert property (sof_enable_q |-> $past(run_control) && ($past(test_active_q) == 3'h5 || $past(test_active_q) == 3'h0))
        else $error("frames sent outside force enable");
    test_exit_a: assert property (controller_reset && controller_halted_flag_q |=> test_active_q == 3'h0)
        else $error("test mode survives reset");
endmodule
bind iso_split_seq iso_split_seq_checker chk (.clk, .reset, .entry_valid, .run_control, .controller_reset,
    .irq_enable, .entry_ready_q, .start_split_q, .controller_halted_flag_q, .test_active_q, .sof_enable_q,
    .irq_threshold_q, .irq_q);

//--- test/tt_model.sv
// transaction translator stand-in answering complete-splits
module tt_model (
    // clock and reset
    input logic clk,
    input logic reset,
    // requests and answer choice
    input logic complete_split_q,
    input logic [1:0] code,
    input logic [2:0] lat,
    // answer
    output logic rsp_valid,
    output logic [1:0] rsp_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= 4'h0;
            rsp_valid <= 1'b0;
            rsp_code <= 2'h0;
        end else begin
            rsp_valid <= cnt == 4'h1;
            // code wanders between answers so nothing leans on a stale value
            rsp_code <= (cnt == 4'h1) ? code : rsp_code + 2'h1;
            cnt <= complete_split_q ? {1'b0, lat} + 4'h1 : cnt - {3'h0, cnt != 4'h0};
        end
    end
endmodule

//--- test/tb_iso_split_seq.sv
// self-checking bench for the split sequencer
module tb_iso_split_seq;
    timeunit 1ns;
    timeprecision 1ps;
    // stream entry in start state, ioc, smask 8'h10, cmask 8'hc3
    localparam logic [23:0] A = 24'h91_0c34;
    localparam logic [23:0] B = 24'hd1_0c34;
    logic clk = 0, reset = 1, entry_valid = 0, uframe_tick = 0, wb_ready = 1, run_control = 1;
    logic controller_reset = 0, device_mode = 0, threshold_write = 0, irq_enable = 1, stall = 0;
    logic [23:0] cur_entry = 0, prev_entry = 0;
    logic [2:0] uframe = 0, port_test_sel = 0, lat = 0;
    logic [7:0] irq_threshold_in = 8'h02;
    logic [1:0] code = 0, seen, rsp_code;
    logic [24:0] wbq[$];
    logic [31:0] r;
    int num_errors = 0, check_count = 0, seed = 32'he1ca_fe76, irqs = 0, takes = 0, i, t0;
    wire entry_ready_q, start_split_q, complete_split_q, use_prev_q, wb_valid_q, wb_is_prev_q, rsp_valid;
    wire controller_halted_flag_q, sof_enable_q, retired_q, irq_q;
    wire [23:0] wb_data_q;
    wire [2:0] test_active_q;
    wire [7:0] irq_threshold_q;
    iso_split_seq dut (.*);
    tt_model tt (.*);
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (start_split_q) seen = 2'h1;
        if (complete_split_q) seen = use_prev_q ? 2'h3 : 2'h2;
        if (wb_valid_q && wb_ready) wbq.push_back({wb_is_prev_q, wb_data_q});
        if (irq_q) irqs++;
        if (entry_ready_q) takes++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            uframe_tick = 1;
            step(1);
            uframe_tick = 0;
            step(3);
        end
    endtask
    function automatic logic [1:0] exp_kind(input logic [23:0] c, input logic [2:0] u);
        if (!c[23]) return 2'h0;
        if (!c[22]) return c[12 + u] ? 2'h1 : 2'h0;
        if (u == 0 && !c[21] || u == 1 && !c[12]) return 2'h3;
        return c[4 + u] ? 2'h2 : 2'h0;
    endfunction
    // one microframe visit; the previous entry is always the live stream entry
    task automatic visit(input logic [23:0] c, input logic [2:0] u, input logic [1:0] rc);
        int n;
        cur_entry = c;
        prev_entry = B;
        uframe = u;
        code = rc;
        entry_valid = 1;
        uframe_tick = 1;
        seen = 0;
        wbq = {};
        step(1);
        uframe_tick = 0;
        for (n = 0; n < 60 && !entry_ready_q; n++) step(1);
        entry_valid = 0;
        wb_ready = !stall;
        step(40);
        chk({n < 60, seen}, {1'b1, exp_kind(c, u)});
    endtask
    task automatic leave;
        for (int n = 0; n < 20 && !controller_halted_flag_q; n++) step(1);
        chk(controller_halted_flag_q, 1);
        port_test_sel = 0;
        controller_reset = 1;
        step(1);
        controller_reset = 0;
        step(2);
    endtask
    initial begin
        repeat (10000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        step(6);
        reset = 0;
        chk(irq_threshold_q, 8'h08);
        threshold_write = 1;
        step(1);
        threshold_write = 0;
        step(1);
        chk(irq_threshold_q, 8'h02);
        for (i = 0; i < 8; i++) begin
            visit(i > 4 ? B : A, i[2:0], 2'h1);
            if (i == 4) chk(wbq[0][24:22], 3'h3);
        end
        visit(B, 3'h0, 2'h2);
        chk(wbq.size(), 1);
        chk({wbq[0][24:23], wbq[0][3:0] != 4'h4}, 3'h7);
        irqs = 0;
        visit(B, 3'h1, 2'h3);
        chk({wbq[0][24:23], wbq[1][24], wbq[1][22], retired_q}, 5'h11);
        chk(irqs, 0);
        tick(2);
        chk(irqs, 1);
        irq_enable = 0;
        visit(B, 3'h1, 2'h3);
        tick(2);
        chk(irqs, 1);
        irq_enable = 1;
        visit(B, 3'h6, 2'h3);
        chk(wbq[0][23:22], 2'h0);
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            lat = r[26:24];
            wb_ready = r[27];
            visit(r[23:0] & 24'hdf_efff, r[30:28], r[1:0]);
        end
        // drain side stalls until the buffer refuses further visits
        stall = 1;
        wb_ready = 0;
        repeat (5) visit(A, 3'h4, 2'h1);
        t0 = takes;
        entry_valid = 1;
        step(20);
        chk(takes - t0, 0);
        stall = 0;
        wb_ready = 1;
        for (i = 0; i < 20 && !entry_ready_q; i++) step(1);
        entry_valid = 0;
        step(20);
        chk(wbq.size(), 6);
        run_control = 0;
        for (i = 1; i < 6; i++) begin
            port_test_sel = i[2:0];
            step(4);
            chk(test_active_q, i);
            if (i == 5) begin
                run_control = 1;
                step(4);
                chk(sof_enable_q, 1);
                run_control = 0;
                step(4);
            end
            leave();
            chk(test_active_q, 0);
        end
        device_mode = 1;
        port_test_sel = 3'h1;
        step(4);
        chk(test_active_q, 0);
        run_control = 1;
        step(4);
        chk(test_active_q, 1);
        run_control = 0;
        leave();
        wrap_up();
    end
endmodule
